// ==== hpir_assertions.sv ====
// checker for host port routing, engine messages and mailbox flags
`timescale 1ns/1ns
`default_nettype none
module hpir_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// host and cpu ports
	input wire hpir_pkg::hpir_acc_t hp_acc,
	input wire logic [15:0] hp_rdata,
	input wire logic host_port_irq,
	input wire hpir_pkg::hpir_acc_t cpu_acc,
	// sources and flags
	input wire hpir_pkg::hpir_src_t src,
	input wire hpir_pkg::hpir_src_t to_cpu,
	input wire logic mbox_rx_full,
	input wire logic mbox_tx_empty
);
	import hpir_pkg::*;
	// mailbox strobes of each side, so same-cycle set and clear can be excluded
	wire h_wm = hp_acc.wr && hp_acc.addr == HPIR_MBOX_ADDR;
	wire h_rm = hp_acc.rd && hp_acc.addr == HPIR_MBOX_ADDR;
	wire c_wm = cpu_acc.wr && cpu_acc.addr == HPIR_MBOX_ADDR;
	wire c_rm = cpu_acc.rd && cpu_acc.addr == HPIR_MBOX_ADDR;
	wire c_msg = cpu_acc.wr && (cpu_acc.addr == HPIR_MSG1_ADDR || cpu_acc.addr == HPIR_MSG2_ADDR);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_MSG_IRQ: assert property (c_msg |-> ##2 host_port_irq)
		else $error("message write gave no host irq");
	AST_MBOX_IRQ: assert property (c_wm |-> ##2 host_port_irq)
		else $error("mailbox write gave no host irq");
	AST_RX_FULL: assert property (h_wm && !c_rm |=> mbox_rx_full)
		else $error("rx full not set");
	AST_RX_CLR: assert property (c_rm && !h_wm |=> !mbox_rx_full)
		else $error("rx full not cleared");
	AST_TX_EMPTY: assert property (h_rm |=> mbox_tx_empty)
		else $error("tx empty not set");
	AST_TX_CLR: assert property (c_wm && !h_rm |=> !mbox_tx_empty)
		else $error("tx empty not cleared");
	AST_CPU_SUBSET: assert property ((to_cpu & ~$past(src)) == '0)
		else $error("cpu interrupt without source");
	AST_RST_IDLE: assert property (disable iff (1'b0) !rst_n |-> !host_port_irq && hp_rdata == '0)
		else $error("outputs active in reset");
	// main scenarios reached
	cover property (mbox_rx_full);
	cover property ($rose(host_port_irq));
	cover property (mbox_tx_empty ##1 !mbox_tx_empty);
endmodule // hpir_checker
bind hpir_core hpir_checker chk (.core_clk(core_clk), .rst_n(rst_n), .hp_acc(hp_acc),
	.hp_rdata(hp_rdata), .host_port_irq(host_port_irq), .cpu_acc(cpu_acc), .src(src),
	.to_cpu(to_cpu), .mbox_rx_full(mbox_rx_full), .mbox_tx_empty(mbox_tx_empty));
`default_nettype wire

// ==== hpir_core.sv ====
// host port interrupt routing, engine messages, mailbox and host status port
`timescale 1ns/1ns
`default_nettype none
module hpir_core (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// host port access, swap applied on the data lines
	input wire hpir_pkg::hpir_acc_t hp_acc,
	input wire logic hp_status_rd,
	output logic [15:0] hp_rdata,
	output logic host_port_irq,
	// on-chip cpu access
	input wire hpir_pkg::hpir_acc_t cpu_acc,
	output logic [15:0] cpu_rdata,
	// interrupt sources and their cpu side copies
	input wire hpir_pkg::hpir_src_t src,
	output var hpir_pkg::hpir_src_t to_cpu,
	// otg pins from outside the clock domain
	input wire logic otg_id_pin,
	input wire logic vbus_valid_pin,
	// mailbox receive-full and transmit-empty interrupt levels
	output logic mbox_rx_full,
	output logic mbox_tx_empty
);
	import hpir_pkg::*;

	hpir_state_t cur;
	hpir_state_t next_cur;

	// byte lane exchange, used on both directions of the host data lines
	function automatic logic [15:0] lane(input logic [15:0] d, input logic swap);
		lane = swap ? {d[7:0], d[15:8]} : d;
	endfunction

	// address decode shared by both ports
	function automatic logic hit(input hpir_acc_t a, input logic [15:0] at);
		hit = a.addr == at;
	endfunction

	logic swap;
	logic [15:0] hp_wd;
	logic [15:0] status;
	logic [15:0] route;
	logic hp_mbox_wr;
	logic hp_mbox_rd;
	logic cpu_mbox_wr;
	logic cpu_mbox_rd;

	// swap acts only when both bits agree on 11, so a mismatched pair stays unswapped
	assign swap = cur.route[HPIR_SWAP_HI] & cur.route[HPIR_SWAP_LO];
	assign hp_wd = lane(hp_acc.wdata, swap);
	assign route = cur.route;
	assign hp_mbox_wr = hp_acc.wr & hit(hp_acc, HPIR_MBOX_ADDR);
	assign hp_mbox_rd = hp_acc.rd & hit(hp_acc, HPIR_MBOX_ADDR);
	assign cpu_mbox_wr = cpu_acc.wr & hit(cpu_acc, HPIR_MBOX_ADDR);
	assign cpu_mbox_rd = cpu_acc.rd & hit(cpu_acc, HPIR_MBOX_ADDR);

	// status word: only routed engine flags show, sources are already enable gated
	always_comb begin
		status = '0;
		status[HPIR_VBUS] = cur.vbus_level;
		status[HPIR_ID] = cur.id_level;
		status[HPIR_SOF2_CPU] = src.sof2 & route[HPIR_SOF2_HP];
		status[HPIR_SOF1_CPU] = src.sof1 & route[HPIR_SOF1_HP];
		status[HPIR_RST2] = src.rst2 & route[HPIR_RST2];
		status[HPIR_MBOX_IN] = cur.mbox_in;
		status[HPIR_RES2] = src.res2 & route[HPIR_RES2];
		status[HPIR_RES1] = src.res1 & route[HPIR_RES1];
		status[HPIR_MSG2] = cur.msg2;
		status[HPIR_MSG1] = cur.msg1;
		status[HPIR_ENGINE2_COMPLETE] = src.engine2_complete & route[HPIR_ENGINE2_COMPLETE];
		status[HPIR_ENGINE1_COMPLETE] = src.engine1_complete & route[HPIR_ENGINE1_COMPLETE];
		status[HPIR_RST1] = src.rst1 & route[HPIR_RST1];
		status[HPIR_MBOX_OUT] = cur.mbox_out;
	end

	// next state
	always_comb begin
		next_cur = cur;
		// three stage synchronisers, a change counts when stages two and three agree
		next_cur.id_sync = {cur.id_sync[1:0], otg_id_pin};
		next_cur.vbus_sync = {cur.vbus_sync[1:0], vbus_valid_pin};
		if (cur.id_sync[2] == cur.id_sync[1]) begin
			next_cur.id_level = cur.id_sync[2];
		end
		if (cur.vbus_sync[2] == cur.vbus_sync[1]) begin
			next_cur.vbus_level = cur.vbus_sync[2];
		end
		// routing register: host port writes, cpu writes ignored
		if (hp_acc.wr && hit(hp_acc, HPIR_ROUTE_ADDR)) begin
			next_cur.route = hp_wd;
		end
		// message flags: host read clears, cpu write sets and wins the same cycle
		if (hp_acc.rd && hit(hp_acc, HPIR_MSG1_ADDR)) begin
			next_cur.msg1 = 1'b0;
		end
		if (hp_acc.rd && hit(hp_acc, HPIR_MSG2_ADDR)) begin
			next_cur.msg2 = 1'b0;
		end
		if (cpu_acc.wr && hit(cpu_acc, HPIR_MSG1_ADDR)) begin
			next_cur.msg1 = 1'b1;
		end
		if (cpu_acc.wr && hit(cpu_acc, HPIR_MSG2_ADDR)) begin
			next_cur.msg2 = 1'b1;
		end
		// mailbox data: last writer wins, host write takes priority on a tie
		if (cpu_mbox_wr) begin
			next_cur.mbox = cpu_acc.wdata;
		end
		if (hp_mbox_wr) begin
			next_cur.mbox = hp_wd;
		end
		// incoming mailbox and receive-full: cleared by cpu read, set by host write
		if (cpu_mbox_rd) begin
			next_cur.mbox_in = 1'b0;
			next_cur.rx_full = 1'b0;
		end
		if (hp_mbox_wr) begin
			next_cur.mbox_in = 1'b1;
			next_cur.rx_full = 1'b1;
		end
		// outgoing mailbox and transmit-empty
		if (hp_mbox_rd) begin
			next_cur.mbox_out = 1'b0;
		end
		if (cpu_mbox_wr) begin
			next_cur.mbox_out = 1'b1;
			next_cur.tx_empty = 1'b0;
		end
		if (hp_mbox_rd) begin
			next_cur.tx_empty = 1'b1;
		end
		// host side read data; the status port never touches the cpu memory path
		next_cur.hp_rdata = '0;
		if (hp_status_rd) begin
			next_cur.hp_rdata = lane(status, swap);
		end else if (hp_acc.rd && hit(hp_acc, HPIR_ROUTE_ADDR)) begin
			next_cur.hp_rdata = lane(cur.route, swap);
		end else if (hp_mbox_rd) begin
			next_cur.hp_rdata = lane(cur.mbox, swap);
		end
		// cpu side read data; no path to the status word exists here
		next_cur.cpu_rdata = '0;
		if (cpu_acc.rd && hit(cpu_acc, HPIR_ROUTE_ADDR)) begin
			next_cur.cpu_rdata = cur.route;
		end else if (cpu_mbox_rd) begin
			next_cur.cpu_rdata = cur.mbox;
		end
		// host pin: or of every pending host side flag
		next_cur.host_irq = (src.vbus & route[HPIR_VBUS])
			| (src.id & route[HPIR_ID])
			| (|status[HPIR_SOF2_CPU:HPIR_RST2])
			| (|status[HPIR_RES2:HPIR_RST1])
			| cur.mbox_out;
		// cpu copies: routing only picks the destination, enables live upstream
		next_cur.to_cpu = src;
		next_cur.to_cpu.vbus = src.vbus & ~route[HPIR_VBUS];
		next_cur.to_cpu.id = src.id & ~route[HPIR_ID];
		next_cur.to_cpu.sof2 = src.sof2 & route[HPIR_SOF2_CPU];
		next_cur.to_cpu.sof1 = src.sof1 & route[HPIR_SOF1_CPU];
		next_cur.to_cpu.rst2 = src.rst2 & ~route[HPIR_RST2];
		next_cur.to_cpu.rst1 = src.rst1 & ~route[HPIR_RST1];
		next_cur.to_cpu.res2 = src.res2 & ~route[HPIR_RES2];
		next_cur.to_cpu.res1 = src.res1 & ~route[HPIR_RES1];
		next_cur.to_cpu.engine2_complete = src.engine2_complete & ~route[HPIR_ENGINE2_COMPLETE];
		next_cur.to_cpu.engine1_complete = src.engine1_complete & ~route[HPIR_ENGINE1_COMPLETE];
	end

	// state register; reset routes everything to the cpu with normal byte order
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
			cur.route <= HPIR_ROUTE_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	assign hp_rdata = cur.hp_rdata;
	assign cpu_rdata = cur.cpu_rdata;
	assign host_port_irq = cur.host_irq;
	assign to_cpu = cur.to_cpu;
	assign mbox_rx_full = cur.rx_full;
	assign mbox_tx_empty = cur.tx_empty;
endmodule // hpir_core
`default_nettype wire

// ==== hpir_host_model.sv ====
// external host processor model issuing host port accesses
`timescale 1ns/1ns
`default_nettype none
module hpir_host_model (
	// clock
	input wire logic core_clk,
	// host port strobes
	output var hpir_pkg::hpir_acc_t hp_acc,
	output var logic hp_status_rd
);
	import hpir_pkg::*;
	initial begin
		hp_acc = '0;
		hp_status_rd = 1'b0;
	end
	// one strobe cycle; idle address and data toggle so stale values never look valid
	// the host never clears a sof/eop interrupt; the cpu side owns that clear
	task automatic acc(input logic w, r, s, input logic [15:0] a, d);
		@(negedge core_clk);
		hp_acc <= '{wr: w, rd: r, addr: a, wdata: d};
		hp_status_rd <= s;
		@(negedge core_clk);
		hp_acc <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		hp_status_rd <= 1'b0;
	endtask
endmodule // hpir_host_model
`default_nettype wire

// ==== hpir_pkg.sv ====
// constants, field layouts and carrier types of the host port interrupt routing and mailbox block
// What this block does
// - a set host routing bit sends that engine interrupt to host_port_irq and the status port
// - routing register is written and read by host port; cpu may only read it
// - routing chooses destination only; enabling stays with the usb_engine enable setting
// - bit 15 moves vbus interrupt, bit 14 moves id interrupt to the host port
// - engine 2 sof/eop: bit 13 to host port, bit 12 to cpu, both allowed
// - engine 1 sof/eop: bit 11 to host port, bit 10 to cpu, both allowed
// - bit 9 moves engine 2 bus reset, bit 1 engine 1 bus reset to host port
// - bit 7 moves host engine 2 resume, bit 6 engine 1 resume to host port
// - bit 3 moves engine2_complete, bit 2 engine1_complete to host port
// - byte swap bits 8 and 0 equal; 00 normal lanes, 11 lanes exchanged
// - any cpu write to an engine_message register sets its flag and raises host_port_irq
// - an engine_message flag clears when the host port reads that register
// - mailbox receive-full fires on host write, clears on cpu mailbox read
// - mailbox transmit-empty fires on host read, clears on cpu mailbox write
// - cpu mailbox write raises host_port_irq until the host reads the mailbox
// - status port readable only from the host side, never by the cpu
// - status port reads make no internal memory access cycle
// - status bit 15 shows vbus above 4.4v; wait 10 us after switching vbus on
// - status bit 14 follows the otg id pin level
// - status bits 12 and 10 show sof/eop interrupt pending on engine 2 and 1
// - status bit 8 flags incoming mailbox message, cleared by cpu mailbox read
// - status bit 0 flags outgoing mailbox message, cleared by host mailbox read
// - status bits 5 and 4 show engine message writes, cleared on host read
package hpir_pkg;
	localparam logic [15:0] HPIR_ROUTE_ADDR = 16'h0142;
	localparam logic [15:0] HPIR_MSG1_ADDR = 16'h0144;
	localparam logic [15:0] HPIR_MSG2_ADDR = 16'h0148;
	localparam logic [15:0] HPIR_MBOX_ADDR = 16'hc0c6;
	// reset value of the routing register: sof/eop to cpu only, normal bytes
	localparam logic [15:0] HPIR_ROUTE_RESET = 16'h1400;
	localparam int HPIR_VBUS = 15;
	localparam int HPIR_ID = 14;
	localparam int HPIR_SOF2_HP = 13;
	localparam int HPIR_SOF2_CPU = 12;
	localparam int HPIR_SOF1_HP = 11;
	localparam int HPIR_SOF1_CPU = 10;
	localparam int HPIR_RST2 = 9;
	localparam int HPIR_SWAP_HI = 8;
	localparam int HPIR_RES2 = 7;
	localparam int HPIR_RES1 = 6;
	localparam int HPIR_MSG2 = 5;
	localparam int HPIR_MSG1 = 4;
	localparam int HPIR_ENGINE2_COMPLETE = 3;
	localparam int HPIR_ENGINE1_COMPLETE = 2;
	localparam int HPIR_RST1 = 1;
	localparam int HPIR_SWAP_LO = 0;
	// status bit 8 is the incoming mailbox flag, bit 0 the outgoing one
	localparam int HPIR_MBOX_IN = 8;
	localparam int HPIR_MBOX_OUT = 0;
	// vbus settle time after switching on, obeyed by software
	localparam int HPIR_VBUS_SETTLE_US = 10;
	localparam int HPIR_CLK_MHZ = 100;
	localparam int HPIR_VBUS_SETTLE_CYC = HPIR_VBUS_SETTLE_US * HPIR_CLK_MHZ;

	// one access on either memory port
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} hpir_acc_t;

	// level interrupt sources from the usb engines and otg logic
	typedef struct packed {
		logic vbus;
		logic id;
		logic sof2;
		logic sof1;
		logic rst2;
		logic rst1;
		logic res2;
		logic res1;
		logic engine2_complete;
		logic engine1_complete;
	} hpir_src_t;

	// whole state of the block
	typedef struct packed {
		logic [15:0] route;
		logic [15:0] mbox;
		logic msg1;
		logic msg2;
		logic mbox_in;
		logic mbox_out;
		logic rx_full;
		logic tx_empty;
		logic [2:0] id_sync;
		logic id_level;
		logic [2:0] vbus_sync;
		logic vbus_level;
		logic [15:0] hp_rdata;
		logic [15:0] cpu_rdata;
		logic host_irq;
		hpir_src_t to_cpu;
	} hpir_state_t;
endpackage

// ==== tb_host_port_irq_routing_mailbox.sv ====
// self-checking bench for the host port routing and mailbox block
`timescale 1ns/1ns
`default_nettype none
module tb_host_port_irq_routing_mailbox;
	import hpir_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic otg_id_pin = 1'b0;
	logic vbus_valid_pin = 1'b0;
	hpir_acc_t hp_acc, cpu_acc = '0;
	hpir_src_t src = '0, to_cpu;
	logic hp_status_rd, host_port_irq, mbox_rx_full, mbox_tx_empty, hv = 0, cv = 0;
	logic [15:0] hp_rdata, cpu_rdata;
	logic [16:0] hq[$], e;
	logic [15:0] cq[$];
	int error_cnt = 0, n_compared = 0;
	logic [31:0] rs = 32'h44;
	always #5 core_clk = ~core_clk;
	hpir_host_model host (.core_clk(core_clk), .hp_acc(hp_acc), .hp_status_rd(hp_status_rd));
	hpir_core dut (.core_clk(core_clk), .rst_n(rst_n), .hp_acc(hp_acc),
		.hp_status_rd(hp_status_rd), .hp_rdata(hp_rdata), .host_port_irq(host_port_irq),
		.cpu_acc(cpu_acc), .cpu_rdata(cpu_rdata), .src(src), .to_cpu(to_cpu),
		.otg_id_pin(otg_id_pin), .vbus_valid_pin(vbus_valid_pin),
		.mbox_rx_full(mbox_rx_full), .mbox_tx_empty(mbox_tx_empty));
	// xorshift generator with a fixed start
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic check(input string n, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// host access; every read notes its expectation, bit 16 says whether it counts
	task automatic h(input logic w, r, s, input logic [15:0] a, d, input logic [16:0] x);
		if (r | s) hq.push_back(x);
		host.acc(w, r, s, a, d);
	endtask
	task automatic c(input logic w, r, input logic [15:0] a, d);
		if (r) cq.push_back(d);
		@(negedge core_clk);
		cpu_acc <= '{wr: w, rd: r, addr: a, wdata: d};
		@(negedge core_clk);
		cpu_acc <= '0;
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// read data appears the cycle after its strobe; the oldest note is compared then
	always @(posedge core_clk) begin
		if (hv) begin
			e = hq.pop_front();
			if (e[16]) check("hp_rdata", hp_rdata, e[15:0]);
		end
		if (cv) check("cpu_rdata", cpu_rdata, cq.pop_front());
		hv <= hp_acc.rd | hp_status_rd;
		cv <= cpu_acc.rd;
	end
	initial begin
		#60000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		logic [15:0] r, d, ma[2];
		logic [9:0] sv;
		ma = '{HPIR_MSG1_ADDR, HPIR_MSG2_ADDR};
		wt(4);
		rst_n <= 1'b1;
		h(0, 1, 0, HPIR_ROUTE_ADDR, 0, {1'b1, HPIR_ROUTE_RESET});
		c(1, 0, HPIR_ROUTE_ADDR, 16'hffff);
		h(0, 1, 0, HPIR_ROUTE_ADDR, 0, {1'b1, HPIR_ROUTE_RESET});
		c(0, 1, HPIR_ROUTE_ADDR, HPIR_ROUTE_RESET);
		// random routes with equal swap bits against random sources
		for (int i = 0; i < 24; i++) begin
			r = 16'(rnd()) & 16'hfefe;
			h(1, 0, 0, HPIR_ROUTE_ADDR, r, 17'h0);
			h(0, 1, 0, HPIR_ROUTE_ADDR, 0, {1'b1, r});
			sv = 10'(rnd());
			src <= hpir_src_t'(sv);
			wt(2);
			check("to_cpu", 16'(to_cpu), 16'(sv & ~{r[15], r[14], ~r[12], ~r[10], r[9], r[1], r[7], r[6], r[3], r[2]}));
			check("irq", 16'(host_port_irq), 16'(|(sv & {r[15], r[14], r[13], r[11], r[9], r[1], r[7], r[6], r[3], r[2]})));
		end
		h(1, 0, 0, HPIR_ROUTE_ADDR, 16'h0000, 17'h0);
		src <= '0;
		// engine messages: any data sets the flag, the host read of the register clears it
		for (int k = 0; k < 2; k++) begin
			c(1, 0, ma[k], 16'(rnd()));
			// flag lands one edge after the write, the pin one edge later still
			wt(2);
			check("msg irq", 16'(host_port_irq), 16'h0001);
			h(0, 0, 1, 0, 0, {1'b1, 16'h0010 << k});
			h(0, 1, 0, ma[k], 0, 17'h0);
			h(0, 0, 1, 0, 0, 17'h10000);
			check("msg irq", 16'(host_port_irq), 16'h0000);
		end
		// mailbox in both directions, then with byte lanes exchanged
		d = 16'(rnd());
		h(1, 0, 0, HPIR_MBOX_ADDR, d, 17'h0);
		check("rx_full", 16'(mbox_rx_full), 16'h0001);
		h(0, 0, 1, 0, 0, 17'h10100);
		c(0, 1, HPIR_MBOX_ADDR, d);
		check("rx_full", 16'(mbox_rx_full), 16'h0000);
		h(0, 1, 0, HPIR_MBOX_ADDR, 0, {1'b1, d});
		check("tx_empty", 16'(mbox_tx_empty), 16'h0001);
		d = 16'(rnd());
		c(1, 0, HPIR_MBOX_ADDR, d);
		check("tx_empty", 16'(mbox_tx_empty), 16'h0000);
		h(0, 0, 1, 0, 0, 17'h10001);
		check("mbox irq", 16'(host_port_irq), 16'h0001);
		h(1, 0, 0, HPIR_ROUTE_ADDR, 16'h0101, 17'h0);
		h(0, 1, 0, HPIR_MBOX_ADDR, 0, {1'b1, d[7:0], d[15:8]});
		wt(1);
		check("mbox irq", 16'(host_port_irq), 16'h0000);
		h(1, 0, 0, HPIR_ROUTE_ADDR, 16'h0000, 17'h0);
		// host waits out the vbus settle time before polling the pin flags
		otg_id_pin <= 1'b1;
		vbus_valid_pin <= 1'b1;
		wt(HPIR_VBUS_SETTLE_CYC);
		h(0, 0, 1, 0, 0, 17'h1c000);
		h(0, 1, 0, 16'h0200, 0, 17'h10000);
		wt(3);
		wrap_up();
	end
endmodule // tb_host_port_irq_routing_mailbox
`default_nettype wire
